//--- design/p9_port.sv
// Port 9 data latch, APB register file and pin selection top
`timescale 1ns/1ns
module p9_port (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    input wire logic serial2_out,
    input wire logic chip_sel_out,
    output logic serial2_in,
    output logic count_down
);
    p9_reg_if regs ();

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // 0x000 output latch; a read gives the port view, the same as 0x014
    // 0x004 direction bits; write-only, reads as all ones
    // 0x008 function select; bits 7 to 5 hand pins 7 to 5 to peripherals
    // 0x00C extra select; bit 0 turns pin 5 into the chip-select output
    // 0x010 timer direction enable; bit 0 lets pin 7 steer the count
    // 0x014 port view; read-only, writes are dropped
    // Any other offset answers with an error, stores nothing and reads zero
    // Only bits 7 to 0 of a word are used; upper write bits are ignored
    // No wait states: a write lands at the edge that ends the access phase,
    // and read data are captured at the end of the setup phase so that
    // they stand still for the whole access phase

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] port9_output_latch;
    logic [7:0] port9_direction_bits;
    logic [7:0] port9_function_select;
    logic port_mode_extra_select;
    logic timer_ext_direction_enable;
    logic [7:0] read_value;
    logic wr_en;
    logic setup_phase;
    logic hit_latch;
    logic hit_dir;
    logic hit_func;
    logic hit_extra;
    logic hit_timer;
    logic hit_pins;
    logic mapped;
    logic wr_latch;
    logic wr_dir;
    logic wr_func;
    logic wr_extra;
    logic wr_timer;
    logic view_sel;
    logic [31:0] extra_word;
    logic [31:0] timer_word;
    logic [31:0] next_prdata;

    // Offset compare, shared by every register select wire
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] offset);
        addr_hit = (addr == offset);
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Access strobes; writes are taken in the access phase only
    assign wr_en = psel & penable & pwrite;
    assign setup_phase = psel & ~penable;
    assign pready = 1'b1; // No wait states
    // Register select
    assign hit_latch = addr_hit(paddr, p9_pkg::ADDR_LATCH);
    assign hit_dir = addr_hit(paddr, p9_pkg::ADDR_DIR);
    assign hit_func = addr_hit(paddr, p9_pkg::ADDR_FUNC);
    assign hit_extra = addr_hit(paddr, p9_pkg::ADDR_EXTRA);
    assign hit_timer = addr_hit(paddr, p9_pkg::ADDR_TIMER);
    assign hit_pins = addr_hit(paddr, p9_pkg::ADDR_PINS);
    assign mapped = hit_latch | hit_dir | hit_func | hit_extra | hit_timer | hit_pins;
    // Unmapped access flags an error in the access phase
    assign pslverr = psel & penable & ~mapped;
    // Write strobes, one per register
    assign wr_latch = wr_en & hit_latch;
    assign wr_dir = wr_en & hit_dir;
    assign wr_func = wr_en & hit_func;
    assign wr_extra = wr_en & hit_extra;
    assign wr_timer = wr_en & hit_timer;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Latch write lands at the write edge
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            port9_output_latch <= p9_pkg::LATCH_RESET;
        end else if (wr_latch) begin
            port9_output_latch <= pwdata[7:0];
        end
    end

    // Direction bits; 1 makes a general pin an output
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            port9_direction_bits <= p9_pkg::DIR_RESET;
        end else if (wr_dir) begin
            port9_direction_bits <= pwdata[7:0];
        end
    end

    // Function select; only bits 7 to 5 steer pins, the rest are kept
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            port9_function_select <= p9_pkg::FUNC_RESET;
        end else if (wr_func) begin
            port9_function_select <= pwdata[7:0];
        end
    end

    // Chip-select mode for pin 5
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            port_mode_extra_select <= p9_pkg::EXTRA_RESET;
        end else if (wr_extra) begin
            port_mode_extra_select <= pwdata[p9_pkg::EXTRA_CS];
        end
    end

    // Timer direction enable for pin 7
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            timer_ext_direction_enable <= p9_pkg::TIMER_RESET;
        end else if (wr_timer) begin
            timer_ext_direction_enable <= pwdata[p9_pkg::TIMER_EXT_DIR];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Single-bit registers placed at their field position in a read word
    assign extra_word = 32'(port_mode_extra_select) << p9_pkg::EXTRA_CS;
    assign timer_word = 32'(timer_ext_direction_enable) << p9_pkg::TIMER_EXT_DIR;
    // Latch and port offsets both give the port view
    assign view_sel = hit_pins | hit_latch;

    // Read selection; the direction register is write-only and reads as all ones
    always_comb begin
        next_prdata = p9_pkg::RDATA_IDLE;
        if (view_sel) begin
            next_prdata[7:0] = read_value;
        end else if (hit_dir) begin
            next_prdata[7:0] = p9_pkg::DIR_READ_VALUE;
        end else if (hit_func) begin
            next_prdata[7:0] = port9_function_select;
        end else if (hit_extra) begin
            next_prdata = extra_word;
        end else if (hit_timer) begin
            next_prdata = timer_word;
        end
    end

    // Read data register: loaded in the setup phase, held through the
    // access phase and cleared when the bus goes idle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= p9_pkg::RDATA_IDLE;
        end else if (setup_phase) begin
            prdata <= pwrite ? p9_pkg::RDATA_IDLE : next_prdata;
        end else if (!psel) begin
            prdata <= p9_pkg::RDATA_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Pin selection
    // ------------------------------------------------------------
    // Pin 7: select 0 gives general I/O by its direction bit,
    //        select 1 the count-direction input whatever the direction bit
    // Pin 6: select 0 gives general I/O by its direction bit,
    //        select 1 drives serial output 2 whatever the direction bit
    // Pin 5: select 0 gives general I/O by its direction bit; with select 1
    //        the chip-select bit picks serial input 2 (0) or chip-select out (1)
    // Pins 4 to 0 always follow their direction and latch bits
    // The port view still reads through the direction bits while a
    // peripheral owns a pin, so software sees latch or pin level there
    // A peripheral input pin left floating in power-down draws current:
    // the board must hold it, or software must hand it back first
    // Register values out to the pin mux
    assign regs.latch = port9_output_latch;
    assign regs.dir = port9_direction_bits;
    assign regs.func = port9_function_select;
    assign regs.cs_sel = port_mode_extra_select;
    assign regs.ext_dir_en = timer_ext_direction_enable;

    // Pin multiplexer and read-back path
    p9_pin_mux u_mux (
        .regs(regs.mux),
        .pin_in(pin_in),
        .serial2_out(serial2_out),
        .chip_sel_out(chip_sel_out),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .read_value(read_value),
        .serial2_in(serial2_in),
        .count_down(count_down)
    );
endmodule

//--- design/p9_pkg.sv
// Package with register map, field positions and reset values of the port 9 block
package p9_pkg;
    localparam int WIDTH = 8;
    // APB byte addresses
    localparam logic [11:0] ADDR_LATCH = 12'h000;
    localparam logic [11:0] ADDR_DIR = 12'h004;
    localparam logic [11:0] ADDR_FUNC = 12'h008;
    localparam logic [11:0] ADDR_EXTRA = 12'h00C;
    localparam logic [11:0] ADDR_TIMER = 12'h010;
    localparam logic [11:0] ADDR_PINS = 12'h014;
    // Reset values and the fixed direction read value
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] FUNC_RESET = 8'h00;
    localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
    localparam logic EXTRA_RESET = 1'b0;
    localparam logic TIMER_RESET = 1'b0;
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
    // Function select field positions
    localparam int SEL_COUNT_DIR = 7;
    localparam int SEL_SERIAL2_OUT = 6;
    localparam int SEL_SERIAL2_IN = 5;
    // Extra select and timer control positions
    localparam int EXTRA_CS = 0;
    localparam int TIMER_EXT_DIR = 0;
    // Pin numbers of the special pins
    localparam int PIN_COUNT_DIR = 7;
    localparam int PIN_SERIAL2_OUT = 6;
    localparam int PIN_SERIAL2_IN = 5;
endpackage

//--- design/p9_reg_if.sv
// Interface carrying register values from the register file to the pin mux
`timescale 1ns/1ns
interface p9_reg_if;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] func;
    logic cs_sel;
    logic ext_dir_en;
    modport regs (output latch, dir, func, cs_sel, ext_dir_en);
    modport mux (input latch, dir, func, cs_sel, ext_dir_en);
endinterface

//--- design/p9_pin_mux.sv
// Pin multiplexer and read-back path for port 9
`timescale 1ns/1ns
module p9_pin_mux (
    p9_reg_if.mux regs,
    input wire logic [7:0] pin_in,
    input wire logic serial2_out,
    input wire logic chip_sel_out,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] read_value,
    output logic serial2_in,
    output logic count_down
);
    logic count_direction_select;
    logic serial2_output_select;
    logic serial2_input_select;
    logic [7:0] gp_use;
    assign count_direction_select = regs.func[p9_pkg::SEL_COUNT_DIR];
    assign serial2_output_select = regs.func[p9_pkg::SEL_SERIAL2_OUT];
    assign serial2_input_select = regs.func[p9_pkg::SEL_SERIAL2_IN];

    // Pins stay general purpose unless their select bit claims them
    always_comb begin
        gp_use = 8'hFF;
        gp_use[p9_pkg::PIN_COUNT_DIR] = ~count_direction_select;
        gp_use[p9_pkg::PIN_SERIAL2_OUT] = ~serial2_output_select;
        gp_use[p9_pkg::PIN_SERIAL2_IN] = ~serial2_input_select;
    end

    // Drivers: direction and latch only count for general pins
    always_comb begin
        pin_out = regs.latch;
        pin_oe = regs.dir & gp_use;
        if (serial2_output_select) begin
            pin_out[p9_pkg::PIN_SERIAL2_OUT] = serial2_out;
            pin_oe[p9_pkg::PIN_SERIAL2_OUT] = 1'b1;
        end
        if (serial2_input_select) begin
            pin_out[p9_pkg::PIN_SERIAL2_IN] = chip_sel_out;
            pin_oe[p9_pkg::PIN_SERIAL2_IN] = regs.cs_sel;
        end
    end

    // Read: latch where direction is 1, pin level where 0
    assign read_value = (regs.latch & regs.dir) | (pin_in & ~regs.dir);
    // Serial input only when selected and not chip select
    assign serial2_in = serial2_input_select & ~regs.cs_sel
        & pin_in[p9_pkg::PIN_SERIAL2_IN];
    // High on the count-direction pin counts down
    assign count_down = count_direction_select & regs.ext_dir_en
        & pin_in[p9_pkg::PIN_COUNT_DIR];
endmodule

//--- bench/p9_asserts.sv
// Checker for the port 9 block
`timescale 1ns/1ns
module p9_asserts (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic serial2_in,
    input wire logic count_down
);
    // Access phase of a transfer
    wire acc = psel && penable;
    // Read of the latch or port offset, both give the port view
    wire view_rd = acc && !pwrite && (paddr == 12'h000 || paddr == 12'h014);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    chk_latch_write: assert property (acc && pwrite && paddr == 12'h000 |=>
        (pin_out[4:0] & pin_oe[4:0]) == ($past(pwdata[4:0]) & pin_oe[4:0])) else $error("bad out");
    chk_reset_idle: assert property ($fell(sys_rst) |-> pin_out == 8'h00 && pin_oe == 8'h00)
        else $error("bad reset");
    chk_port_read: assert property (view_rd |->
        prdata[4:0] == (($past(pin_out[4:0]) & $past(pin_oe[4:0]))
        | ($past(pin_in[4:0]) & ~$past(pin_oe[4:0]))))
        else $error("bad port read");
    chk_dir_read: assert property (acc && !pwrite && paddr == 12'h004 |-> prdata == 32'hFF)
        else $error("bad dir read");
    chk_count_src: assert property (count_down |-> pin_in[7] && !pin_oe[7])
        else $error("bad count");
    chk_serial_in_src: assert property (serial2_in |-> pin_in[5] && !pin_oe[5])
        else $error("bad serial in");
    chk_bad_addr: assert property (acc && paddr > 12'h014 |-> pslverr && prdata == 32'h0)
        else $error("bad error");
    chk_zero_wait: assert property (acc |-> pready) else $error("no ready");
endmodule

//--- bench/p9_pins_model.sv
// Board model setting port 9 pin levels
`timescale 1ns/1ns
module p9_pins_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // Released pins held at a board level, never floating
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

//--- bench/p9_port_tb_top.sv
// Testbench for the port 9 block
`timescale 1ns/1ns
module p9_port_tb_top;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, serial2_in, count_down;
    logic [7:0] pin_in, pin_out, pin_oe;
    logic [7:0] ext_level = 8'h00;
    logic serial2_out = 1'b0;
    logic chip_sel_out = 1'b0;
    int num_errors = 0;
    int n_tests = 0;
    always #5 clock = ~clock;
    p9_port dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .serial2_out(serial2_out), .chip_sel_out(chip_sel_out), .serial2_in(serial2_in),
        .count_down(count_down));
    p9_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in));
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic t_gpio();
        chk("oe", 32'(pin_oe), 32'h0);
        chk("out", 32'(pin_out), 32'h0);
        ext_level <= 8'h5A;
        apb(1'b0, 12'h000, 32'h0);
        chk("latch", rd, 32'h5A);
        apb(1'b1, 12'h004, 32'hFF);
        apb(1'b1, 12'h000, 32'hA5);
        chk("out", 32'(pin_out), 32'hA5);
        chk("oe", 32'(pin_oe), 32'hFF);
        apb(1'b0, 12'h000, 32'h0);
        chk("latch", rd, 32'hA5);
        apb(1'b1, 12'h004, 32'h0F);
        @(posedge clock);
        ext_level <= 8'h3C;
        apb(1'b0, 12'h014, 32'h0);
        chk("port", rd, 32'h35);
        $display("gpio end");
    endtask
    task automatic t_func();
        apb(1'b1, 12'h004, 32'hFF);
        apb(1'b1, 12'h000, 32'h00);
        apb(1'b1, 12'h010, 32'h01);
        @(posedge clock);
        serial2_out <= 1'b1;
        ext_level <= 8'hA0;
        apb(1'b1, 12'h008, 32'hE0);
        chk("serial2_out", 32'(pin_out[6]), 32'h1);
        chk("oe", 32'(pin_oe[7:5]), 32'h2);
        chk("down", 32'(count_down), 32'h1);
        chk("serial2_in", 32'(serial2_in), 32'h1);
        apb(1'b0, 12'h014, 32'h0);
        chk("port", rd, 32'h0);
        @(posedge clock);
        chip_sel_out <= 1'b1;
        apb(1'b1, 12'h00C, 32'h01);
        chk("cs", 32'({pin_oe[5], pin_out[5]}), 32'h3);
        chk("serial2_in", 32'(serial2_in), 32'h0);
        apb(1'b1, 12'h010, 32'h00);
        chk("down", 32'(count_down), 32'h0);
        apb(1'b1, 12'h008, 32'h00);
        chk("out", 32'(pin_out), 32'h0);
        apb(1'b1, 12'h018, 32'hFF);
        chk("err", 32'(er), 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk("dir", rd, 32'hFF);
        chk("err", 32'(er), 32'h0);
        $display("func end");
    endtask
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        t_gpio();
        t_func();
        stop_test();
    end
endmodule
bind p9_port p9_asserts chk_i (.*);
